/* mcsl_delay_line.sv */
// mcsl_delay_line: programmable delay of a bit vector, used to equalise
// fibre delay; assumes the delay never exceeds DEPTH-1 cycles
`timescale 1ns/10ps
module mcsl_delay_line #(
  parameter int unsigned WIDTH = 8,   // bits per word
  parameter int unsigned AW    = 8    // log2 of depth
) (
  input  wire logic             ref_clk,  // system clock
  input  wire logic             reset_n,  // async reset, active low
  input  wire logic [WIDTH-1:0] din,      // word written every cycle
  input  wire logic [AW-1:0]    delay,    // added delay in cycles
  output logic      [WIDTH-1:0] dout_ff   // delayed word, registered
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0]    wr_ptr_ff;

  // circular buffer written every cycle
  always_ff @(posedge ref_clk) begin
    mem[wr_ptr_ff] <= din;
  end

  // pointer advance
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) wr_ptr_ff <= '0;
    else          wr_ptr_ff <= wr_ptr_ff + 1'b1;
  end

  // registered read behind the write pointer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) dout_ff <= '0;
    else          dout_ff <= (delay == '0) ? din : mem[wr_ptr_ff - delay]; // zero delay bypasses the slot being written
  end

endmodule // mcsl_delay_line

/* mcsl_edge_filter.sv */
// mcsl_edge_filter: glitch filter, edge select and same-kind lockout for one
// external start or stop line; assumes the line is synchronous to ref_clk
`timescale 1ns/10ps
module mcsl_edge_filter #(
  parameter int unsigned MIN_CYC  = mcsl_pkg::MIN_PULSE_CYC,  // least stable time
  parameter int unsigned LOCK_CYC = mcsl_pkg::LOCKOUT_CYC     // lockout length
) (
  input  wire logic                ref_clk,   // system clock
  input  wire logic                reset_n,   // async reset, active low
  input  wire logic                line_in,   // raw input level
  input  mcsl_pkg::mcsl_edge_e     edge_mode, // disabled, rising, falling
  output logic                     event_ff   // accepted event pulse
);
  import mcsl_pkg::*;

  logic [CNT_W-1:0] stab_cnt_ff;
  logic [CNT_W-1:0] lock_cnt_ff;
  logic             raw_ff;
  logic             level_ff;
  logic             nxt_level;
  logic             rise;
  logic             fall;
  logic             hit;

  // a level counts only once stable for MIN_CYC cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_ff      <= 1'b1;
      stab_cnt_ff <= '0;
    end else begin
      raw_ff <= line_in;
      if (line_in != raw_ff)
        stab_cnt_ff <= '0;
      else if (stab_cnt_ff < CNT_W'(MIN_CYC))
        stab_cnt_ff <= stab_cnt_ff + 1'b1;
    end
  end

  // filtered level follows raw once stable; shorter pulses never reach it
  always_comb begin
    nxt_level = level_ff;
    if (stab_cnt_ff >= CNT_W'(MIN_CYC - 1)) nxt_level = raw_ff;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) level_ff <= 1'b1;
    else          level_ff <= nxt_level;
  end

  assign rise = nxt_level & ~level_ff;
  assign fall = ~nxt_level & level_ff;
  assign hit  = ((edge_mode == MCSL_EDGE_RISE) && rise) ||
                ((edge_mode == MCSL_EDGE_FALL) && fall);

  // event pulse and lockout of the same kind
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_ff    <= 1'b0;
      lock_cnt_ff <= '0;
    end else begin
      event_ff <= 1'b0;
      if (lock_cnt_ff != '0) begin
        lock_cnt_ff <= lock_cnt_ff - 1'b1;
      end else if (hit) begin
        event_ff    <= 1'b1;
        lock_cnt_ff <= CNT_W'(LOCK_CYC);
      end
    end
  end

endmodule // mcsl_edge_filter

/* mcsl_partner.sv */
// mcsl_partner: far chassis acting as follower on the fibre
// assumes it shares ref_clk with the leader under test
`timescale 1ns/10ps
module mcsl_partner
  import mcsl_pkg::*;
#(
  parameter int unsigned LAT = 6,                                        // fibre delay cycles
  parameter int unsigned W   = mcsl_pkg::TRIG_W + mcsl_pkg::FRM_CTRL_W   // word width
) (
  input  wire logic         ref_clk,    // clock
  input  wire logic [1:0]   link_lvl,   // 0 dark, 1 aligned, 2 data
  input  wire logic [W-1:0] tx_word,    // word from leader
  input  wire logic         tx_en,      // leader light on
  output logic              rx_sig_det, // light seen
  output logic              rx_aligned, // alignment found
  output logic              rx_valid,   // data valid
  output logic [W-1:0]      rx_word     // word sent back
);
  logic [W-1:0] dly [LAT];
  initial rx_word = '0;
  // align comes back as echo, triggers travel back; dead line toggles
  always @(posedge ref_clk) begin
    dly[0] <= {tx_word[W-1:FRM_ECHO+1], tx_word[FRM_ALIGN], 1'b0, tx_word[FRM_CALC:0]};
    for (int i = 1; i < LAT; i++) begin
      dly[i] <= dly[i-1];
    end
    rx_sig_det <= tx_en && link_lvl != 2'h0;
    rx_aligned <= tx_en && link_lvl != 2'h0;
    rx_valid   <= tx_en && link_lvl == 2'h2;
    rx_word    <= (tx_en && link_lvl == 2'h2) ? dly[LAT-1] : ~rx_word;
  end
endmodule // mcsl_partner

/* mcsl_pkg.sv */
// mcsl_pkg: constants, enums and timing counts for the multi chassis sync link
// assumes a 50 MHz ref_clk; times are converted to cycles here
package mcsl_pkg;

  // clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;

  // start/stop glitch rejection, least time -> round up
  localparam int unsigned MIN_PULSE_NS    = 500;
  localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // same-kind lockout after an accepted start or stop
  localparam int unsigned LOCKOUT_MS      = 100;
  localparam int unsigned LOCKOUT_CYC     = LOCKOUT_MS * (CLK_HZ / 1000);

  // sweep end pulse, nominal 500 ms within +/-100 ms
  localparam int unsigned SWEEP_PULSE_MS  = 500;
  localparam int unsigned SWEEP_TOL_MS    = 100;
  localparam int unsigned SWEEP_PULSE_CYC = SWEEP_PULSE_MS * (CLK_HZ / 1000);

  // widths
  localparam int unsigned TRIG_W          = 8;
  localparam int unsigned DELAY_W         = 16;
  localparam int unsigned CNT_W           = 26;

  // link frame: trigger bits plus control bits
  localparam int unsigned FRM_START       = 0;
  localparam int unsigned FRM_PAUSE       = 1;
  localparam int unsigned FRM_MANUAL      = 2;
  localparam int unsigned FRM_CALC        = 3;
  localparam int unsigned FRM_ALIGN       = 4;
  localparam int unsigned FRM_ECHO        = 5;
  localparam int unsigned FRM_CTRL_W      = 6;

  // link role
  typedef enum logic [1:0] {
    MCSL_UNUSED,
    MCSL_LEADER,
    MCSL_FOLLOWER
  } mcsl_role_e;

  // link state shown on the indicators
  typedef enum logic [1:0] {
    MCSL_NO_LINK,
    MCSL_SIG_DET,
    MCSL_DATA_OK
  } mcsl_link_e;

  // time source on the leader
  typedef enum logic [1:0] {
    MCSL_TS_RTC,
    MCSL_TS_PTP,
    MCSL_TS_IRIG,
    MCSL_TS_GPS
  } mcsl_tsrc_e;

  // event output source
  typedef enum logic [1:0] {
    MCSL_EO_ALARM,
    MCSL_EO_REC_ACTIVE,
    MCSL_EO_SWEEP_END
  } mcsl_evsel_e;

  // start/stop edge setting
  typedef enum logic [1:0] {
    MCSL_EDGE_OFF,
    MCSL_EDGE_RISE,
    MCSL_EDGE_FALL
  } mcsl_edge_e;

endpackage

/* mcsl_top.sv */
// mcsl_top: multi chassis sync link logic plus front I/O event lines
// assumes a serdes below gives decoded words with signal/align/valid flags
`timescale 1ns/10ps
module mcsl_top
  import mcsl_pkg::*;
#(
  parameter int unsigned TRIG_BITS  = mcsl_pkg::TRIG_W,          // shared trigger lines
  parameter int unsigned DLY_AW     = 8,                         // delay line address width
  parameter int unsigned MIN_CYC    = mcsl_pkg::MIN_PULSE_CYC,   // glitch filter cycles
  parameter int unsigned LOCK_CYC   = mcsl_pkg::LOCKOUT_CYC,     // start/stop lockout cycles
  parameter int unsigned SWEEP_CYC  = mcsl_pkg::SWEEP_PULSE_CYC  // sweep end pulse cycles
) (
  input  wire logic                    ref_clk,          // system clock 50 MHz
  input  wire logic                    reset_n,          // async reset, active low
  // configuration
  input  mcsl_pkg::mcsl_role_e         role_req,         // requested link role
  input  mcsl_pkg::mcsl_tsrc_e         tsrc_req,         // requested time source
  input  mcsl_pkg::mcsl_evsel_e        evout_sel,        // event output source
  input  wire logic                    evin_to_arm,      // 1 routes event in to trigger arm
  input  mcsl_pkg::mcsl_edge_e         start_mode,       // external start edge
  input  mcsl_pkg::mcsl_edge_e         stop_mode,        // external stop edge
  // local recorder
  input  wire logic                    rec_active,       // recording in progress
  input  wire logic                    sweep_done,       // sweep completed pulse
  input  wire logic                    trig_armed_mode,  // recording in trigger-arm mode
  input  wire logic                    alarm_ch,         // or of channel alarms
  input  wire logic                    alarm_calc,       // calc engine alarms
  input  wire logic [TRIG_BITS-1:0]    loc_trig,         // local channel triggers
  input  wire logic                    loc_first_smp,    // local first-sample marker
  input  wire logic                    loc_start,        // software start request
  input  wire logic                    loc_pause,        // software pause request
  input  wire logic                    loc_manual,       // software manual trigger
  input  wire logic                    loc_calc_trig,    // computed channel trigger
  input  wire logic                    smp_tick,         // local sample clock tick
  // front I/O, active low pins
  input  wire logic                    ev_in_n,          // external event in
  input  wire logic                    start_in_n,       // external start in
  input  wire logic                    stop_in_n,        // external stop in
  // serdes side
  input  wire logic                    rx_sig_det,       // optical signal seen
  input  wire logic                    rx_aligned,       // alignment chars found
  input  wire logic                    rx_valid,         // valid data word
  input  wire logic [TRIG_BITS+FRM_CTRL_W-1:0] rx_word,  // received word
  output logic      [TRIG_BITS+FRM_CTRL_W-1:0] tx_word_ff, // word to send
  output logic                         tx_en_ff,         // transmitter on
  // results
  output logic                         led_sig_ff,       // signal detect LED
  output logic                         led_data_ff,      // data LED
  output logic [TRIG_BITS-1:0]         sys_trig_ff,      // aligned trigger bus
  output logic                         sys_first_smp_ff, // aligned first sample
  output logic                         sys_start_ff,     // aligned start
  output logic                         sys_pause_ff,     // aligned pause
  output logic                         sys_stop_ff,      // local stop
  output logic                         sys_manual_ff,    // aligned manual trigger
  output logic                         sys_calc_ff,      // aligned calc trigger
  output logic                         smp_lock_ff,      // follow leader sample tick
  output logic                         smp_tick_out_ff,  // sample tick in use
  output logic                         time_rec_en_ff,   // this chassis records time
  output mcsl_pkg::mcsl_tsrc_e         tsrc_ff,          // time source in force
  output mcsl_pkg::mcsl_role_e         role_ff,          // role in force
  output logic                         cyc_event_ff,     // calc engine cycle event
  output logic                         trig_arm_ff,      // trigger arm
  output logic                         ev_out_ff,        // external event out
  output logic [DELAY_W-1:0]           rtt_ff            // measured round trip
);
  import mcsl_pkg::*;

  localparam int unsigned FW = TRIG_BITS + FRM_CTRL_W;

  mcsl_link_e         link_ff;
  logic               rx_ok;
  logic [FW-1:0]      rx_eff;
  logic [FW-1:0]      tx_nxt;
  logic [FW-1:0]      loc_word;
  logic [FW-1:0]      loc_dly;
  logic [DELAY_W-1:0] meas_cnt_ff;
  logic               meas_run_ff;
  logic [DLY_AW-1:0]  comp_ff;
  logic               ev_in_d_ff;
  logic               start_evt;
  logic               stop_evt;
  logic [CNT_W-1:0]   sweep_cnt_ff;

  // role and time source take effect only between recordings
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      role_ff <= MCSL_UNUSED;
      tsrc_ff <= MCSL_TS_RTC;
    end else if (!rec_active) begin
      role_ff <= role_req;
      tsrc_ff <= tsrc_req;
    end
  end

  // time recording only on leader or standalone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) time_rec_en_ff <= 1'b1;
    else          time_rec_en_ff <= (role_ff != MCSL_FOLLOWER);
  end

  // link state, signal loss returns to no link
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      link_ff <= MCSL_NO_LINK;
    else if (role_ff == MCSL_UNUSED || !rx_sig_det)
      link_ff <= MCSL_NO_LINK;
    else if (rx_valid && rx_aligned)
      link_ff <= MCSL_DATA_OK;
    else if (rx_aligned)
      link_ff <= MCSL_SIG_DET;
    else
      link_ff <= MCSL_NO_LINK;
  end

  // indicators
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      led_sig_ff  <= 1'b0;
      led_data_ff <= 1'b0;
    end else begin
      led_sig_ff  <= (link_ff != MCSL_NO_LINK);
      led_data_ff <= (link_ff == MCSL_DATA_OK);
    end
  end

  // received content only counts in a live link and an active role
  assign rx_ok  = (link_ff == MCSL_DATA_OK) && rx_valid && (role_ff != MCSL_UNUSED);
  assign rx_eff = rx_ok ? rx_word : '0;

  // local word: triggers plus extended-sync control bits
  always_comb begin
    loc_word = '0;
    loc_word[FRM_START]  = loc_start | start_evt;
    loc_word[FRM_PAUSE]  = loc_pause;
    loc_word[FRM_MANUAL] = loc_manual;
    loc_word[FRM_CALC]   = loc_calc_trig;
    loc_word[FRM_ALIGN]  = loc_first_smp;
    loc_word[FW-1:FRM_CTRL_W] = loc_trig;
  end

  // transmit: leader sends its word, follower echoes align for ranging
  always_comb begin
    tx_nxt = loc_word;
    if (role_ff == MCSL_FOLLOWER) begin
      tx_nxt[FRM_ALIGN] = 1'b0;
      tx_nxt[FRM_ECHO]  = rx_eff[FRM_ALIGN];
    end
    if (role_ff == MCSL_UNUSED)
      tx_nxt = '0;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_word_ff <= '0;
      tx_en_ff   <= 1'b0;
    end else begin
      tx_word_ff <= tx_nxt;
      tx_en_ff   <= (role_ff != MCSL_UNUSED);
    end
  end

  // leader ranges the fibre: count from sent align to its echo
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meas_run_ff <= 1'b0;
      meas_cnt_ff <= '0;
      rtt_ff      <= '0;
    end else if (role_ff != MCSL_LEADER) begin
      meas_run_ff <= 1'b0;
    end else if (tx_nxt[FRM_ALIGN] && !meas_run_ff) begin
      meas_run_ff <= 1'b1;
      meas_cnt_ff <= '0;
    end else if (meas_run_ff) begin
      meas_cnt_ff <= meas_cnt_ff + 1'b1;
      if (rx_eff[FRM_ECHO]) begin
        meas_run_ff <= 1'b0;
        rtt_ff      <= meas_cnt_ff + 1'b1;
      end
    end
  end

  // leader holds its own events back by the one-way delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      comp_ff <= '0;
    else
      comp_ff <= DLY_AW'(rtt_ff >> 1);
  end

  mcsl_delay_line #(
    .WIDTH (FW),
    .AW    (DLY_AW)
  ) u_comp (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (loc_word),
    .delay   (comp_ff),
    .dout_ff (loc_dly)
  );

  // merge of local and received events onto the system lines
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_trig_ff      <= '0;
      sys_first_smp_ff <= 1'b0;
      sys_start_ff     <= 1'b0;
      sys_pause_ff     <= 1'b0;
      sys_manual_ff    <= 1'b0;
      sys_calc_ff      <= 1'b0;
    end else begin
      unique case (role_ff)
        MCSL_LEADER: begin
          sys_trig_ff      <= loc_dly[FW-1:FRM_CTRL_W] | rx_eff[FW-1:FRM_CTRL_W];
          sys_first_smp_ff <= loc_dly[FRM_ALIGN];
          sys_start_ff     <= loc_dly[FRM_START];
          sys_pause_ff     <= loc_dly[FRM_PAUSE];
          sys_manual_ff    <= loc_dly[FRM_MANUAL] | rx_eff[FRM_MANUAL];
          sys_calc_ff      <= loc_dly[FRM_CALC] | rx_eff[FRM_CALC];
        end
        MCSL_FOLLOWER: begin
          sys_trig_ff      <= rx_eff[FW-1:FRM_CTRL_W] | loc_trig;
          sys_first_smp_ff <= rx_eff[FRM_ALIGN];
          sys_start_ff     <= rx_eff[FRM_START];
          sys_pause_ff     <= rx_eff[FRM_PAUSE];
          sys_manual_ff    <= rx_eff[FRM_MANUAL];
          sys_calc_ff      <= rx_eff[FRM_CALC];
        end
        MCSL_UNUSED: begin
          sys_trig_ff      <= loc_trig;
          sys_first_smp_ff <= loc_first_smp;
          sys_start_ff     <= loc_word[FRM_START];
          sys_pause_ff     <= loc_pause;
          sys_manual_ff    <= loc_manual;
          sys_calc_ff      <= loc_calc_trig;
        end
        default: begin
          sys_trig_ff      <= '0;
          sys_first_smp_ff <= 1'b0;
          sys_start_ff     <= 1'b0;
          sys_pause_ff     <= 1'b0;
          sys_manual_ff    <= 1'b0;
          sys_calc_ff      <= 1'b0;
        end
      endcase
    end
  end

  // follower takes the sample tick from the leader word stream
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_lock_ff     <= 1'b0;
      smp_tick_out_ff <= 1'b0;
    end else begin
      smp_lock_ff     <= (role_ff == MCSL_FOLLOWER) && rx_ok;
      smp_tick_out_ff <= smp_lock_ff ? rx_valid : smp_tick;
    end
  end

  // external start/stop inputs, each with its own filter and lockout
  mcsl_edge_filter #(
    .MIN_CYC  (MIN_CYC),
    .LOCK_CYC (LOCK_CYC)
  ) u_start (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .line_in   (start_in_n),
    .edge_mode (start_mode),
    .event_ff  (start_evt)
  );

  mcsl_edge_filter #(
    .MIN_CYC  (MIN_CYC),
    .LOCK_CYC (LOCK_CYC)
  ) u_stop (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .line_in   (stop_in_n),
    .edge_mode (stop_mode),
    .event_ff  (stop_evt)
  );

  // stop is local and not carried over the link
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) sys_stop_ff <= 1'b0;
    else          sys_stop_ff <= stop_evt;
  end

  // event input: active low, routed to cycle event or trigger arm
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_in_d_ff   <= 1'b0;
      cyc_event_ff <= 1'b0;
      trig_arm_ff  <= 1'b0;
    end else begin
      ev_in_d_ff   <= ~ev_in_n;
      cyc_event_ff <= ~ev_in_n & ~ev_in_d_ff & ~evin_to_arm;
      trig_arm_ff  <= ~ev_in_n & evin_to_arm;
    end
  end

  // sweep end pulse timer, restarts on each completed sweep while recording in trigger-arm mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sweep_cnt_ff  <= '0;
    end else begin
      if (sweep_done && trig_armed_mode && rec_active)
        sweep_cnt_ff <= CNT_W'(SWEEP_CYC);
      else if (sweep_cnt_ff != '0)
        sweep_cnt_ff <= sweep_cnt_ff - 1'b1;
    end
  end

  // event output select
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      ev_out_ff <= 1'b0;
    else begin
      unique case (evout_sel)
        MCSL_EO_ALARM:      ev_out_ff <= alarm_ch | alarm_calc;
        MCSL_EO_REC_ACTIVE: ev_out_ff <= rec_active;
        MCSL_EO_SWEEP_END:  ev_out_ff <= (sweep_cnt_ff != '0);
        default:            ev_out_ff <= 1'b0;
      endcase
    end
  end

endmodule // mcsl_top

/* mcsl_top_properties.sv */
// mcsl_top_properties: port timing checks for mcsl_top
// assumes one clock domain; bound from the testbench
`timescale 1ns/10ps
module mcsl_top_properties
  import mcsl_pkg::*;
(
  input wire logic            ref_clk,        // clock
  input wire logic            reset_n,        // reset, low
  input mcsl_pkg::mcsl_role_e role_ff,        // role
  input wire logic            tx_en_ff,       // light on
  input wire logic            led_sig_ff,     // led 1
  input wire logic            led_data_ff,    // led 2
  input wire logic            rx_sig_det,     // light in
  input wire logic            rx_aligned,     // aligned
  input wire logic            rx_valid,       // valid
  input wire logic            time_rec_en_ff, // time rec
  input wire logic            rec_active,     // recording
  input mcsl_pkg::mcsl_evsel_e evout_sel,     // out source
  input wire logic            ev_out_ff,      // event out
  input wire logic            cyc_event_ff,   // cycle event
  input wire logic            sys_stop_ff     // stop pulse
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // full link seen while a role is active
  sequence s_link;
    rx_sig_det && rx_aligned && rx_valid && role_ff != MCSL_UNUSED;
  endsequence
  property p_unused; role_ff == MCSL_UNUSED |=> !tx_en_ff; endproperty
  a_unused: assert property (p_unused) else $error("light on while unused");
  property p_dark; !rx_sig_det |-> ##2 !led_sig_ff; endproperty
  a_dark: assert property (p_dark) else $error("led on without light");
  property p_data; s_link [*3] |-> led_data_ff && led_sig_ff; endproperty
  a_data: assert property (p_data) else $error("leds off on good link");
  property p_follow; (role_ff == MCSL_FOLLOWER) [*3] |-> !time_rec_en_ff; endproperty
  a_follow: assert property (p_follow) else $error("follower records time");
  property p_hold; rec_active |=> $stable(role_ff); endproperty
  a_hold: assert property (p_hold) else $error("role changed in recording");
  property p_rec; evout_sel == MCSL_EO_REC_ACTIVE && $past(evout_sel) == MCSL_EO_REC_ACTIVE
    |-> ev_out_ff == $past(rec_active); endproperty
  a_rec: assert property (p_rec) else $error("event out not following recording");
  property p_cyc; cyc_event_ff |=> !cyc_event_ff; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle event longer than one cycle");
  property p_lock; sys_stop_ff |=> !sys_stop_ff [*8]; endproperty
  a_lock: assert property (p_lock) else $error("stop repeated in lockout");
endmodule // mcsl_top_properties

/* mcsl_top_test.sv */
// mcsl_top_test: self-checking bench for mcsl_top with a follower far side
// assumes shortened filter, lockout and sweep counts
`timescale 1ns/10ps
module mcsl_top_test;
  import mcsl_pkg::*;
  localparam int MINC = 4, LOCK = 50, SWP = 40, LAT = 6;
  logic ref_clk = 0, reset_n = 0, evin_to_arm = 0, rec_active = 0, sweep_done = 0, trig_armed_mode = 0;
  logic alarm_ch = 0, alarm_calc = 0, loc_first_smp = 0, loc_start = 0, loc_pause = 0, loc_manual = 0;
  logic loc_calc_trig = 0, smp_tick = 0, ev_in_n = 1, start_in_n = 1, stop_in_n = 1, rx_sig_det, rx_aligned;
  logic rx_valid, tx_en_ff, led_sig_ff, led_data_ff, sys_first_smp_ff, sys_start_ff, sys_pause_ff, sys_stop_ff;
  logic sys_manual_ff, sys_calc_ff, smp_lock_ff, smp_tick_out_ff, time_rec_en_ff, cyc_event_ff, trig_arm_ff, ev_out_ff;
  logic [7:0] loc_trig = 0, sys_trig_ff, lf = 8'h5A;
  logic [13:0] rx_word, tx_word_ff;
  logic [15:0] rtt_ff;
  logic [1:0] link_lvl = 0;
  mcsl_role_e role_req = MCSL_UNUSED, role_ff;
  mcsl_tsrc_e tsrc_req = MCSL_TS_RTC, tsrc_ff;
  mcsl_evsel_e evout_sel = MCSL_EO_ALARM;
  mcsl_edge_e start_mode = MCSL_EDGE_OFF, stop_mode = MCSL_EDGE_OFF;
  int error_cnt = 0, n_compared = 0, n;
  always #10 ref_clk = ~ref_clk;
  mcsl_top #(.MIN_CYC(MINC), .LOCK_CYC(LOCK), .SWEEP_CYC(SWP)) dut_u (.*);
  mcsl_partner #(.LAT(LAT)) far_u (.ref_clk(ref_clk), .link_lvl(link_lvl), .tx_word(tx_word_ff), .tx_en(tx_en_ff),
    .rx_sig_det(rx_sig_det), .rx_aligned(rx_aligned), .rx_valid(rx_valid), .rx_word(rx_word));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // counts high cycles of stop (+2 per start), cycle event, event out or first sample
  task hi(input int c, input int k);
    repeat (c) begin
      cyc(1);
      n += (k == 0) ? sys_stop_ff + 2 * sys_start_ff : (k == 1) ? cyc_event_ff : (k == 2) ? ev_out_ff : sys_first_smp_ff;
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end
  // main sequence
  initial begin
    cyc(10);
    reset_n = 1;
    cyc(1);
    chk("role", MCSL_UNUSED, role_ff);
    link_lvl = 2;
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      loc_trig = lf;
      {loc_manual, loc_calc_trig, loc_pause} = lf[2:0];
      cyc(1);
      chk("tx_word", 0, tx_word_ff);
      chk("sys_trig", lf, sys_trig_ff);
      chk("sys_ctl", lf[2:0], {sys_manual_ff, sys_calc_ff, sys_pause_ff});
    end
    chk("leds", 0, {led_sig_ff, led_data_ff});
    $display("done unused");
    role_req = MCSL_LEADER;
    cyc(8);
    chk("leds", 3, {led_sig_ff, led_data_ff});
    chk("time_rec", 1, time_rec_en_ff);
    loc_first_smp = 1;
    cyc(1);
    loc_first_smp = 0;
    n = 0;
    hi(3 * LAT, 3);
    chk("rtt", 1, rtt_ff >= LAT && rtt_ff <= LAT + 4);
    chk("first_smp", 1, n[15:0]);
    link_lvl = 1;
    cyc(4);
    chk("leds", 2, {led_sig_ff, led_data_ff});
    link_lvl = 0;
    cyc(4);
    chk("leds", 0, {led_sig_ff, led_data_ff});
    rec_active = 1;
    role_req = MCSL_FOLLOWER;
    tsrc_req = MCSL_TS_GPS;
    cyc(4);
    chk("tsrc", MCSL_TS_RTC, tsrc_ff);
    rec_active = 0;
    cyc(4);
    chk("tsrc", MCSL_TS_GPS, tsrc_ff);
    chk("time_rec", 0, time_rec_en_ff);
    role_req = MCSL_UNUSED;
    $display("done link");
    for (int m = 0; m < 3; m++) begin
      stop_mode = mcsl_edge_e'(m);
      start_mode = stop_mode;
      for (int w = 0; w < 4; w++) begin
        if (w == 0 || w == 3) cyc(LOCK);
        n = 0;
        {start_in_n, stop_in_n} = 2'h0;
        hi(w == 0 ? MINC - 1 : w == 1 ? MINC : MINC + 6, 0);
        {start_in_n, stop_in_n} = 2'h3;
        hi(MINC + 8, 0);
        chk("start_stop", 3 * (m != 0 && w % 2 == 1), n[15:0]);
      end
    end
    $display("done stop");
    evin_to_arm = 1;
    ev_in_n = 0;
    cyc(4);
    chk("arm", 1, trig_arm_ff);
    ev_in_n = 1;
    evin_to_arm = 0;
    cyc(4);
    ev_in_n = 0;
    n = 0;
    hi(6, 1);
    chk("cyc_ev", 1, n[15:0]);
    ev_in_n = 1;
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      {alarm_ch, alarm_calc} = lf[1:0];
      cyc(2);
      chk("ev_out", |lf[1:0], ev_out_ff);
    end
    evout_sel = MCSL_EO_REC_ACTIVE;
    rec_active = 1;
    cyc(2);
    chk("ev_out", 1, ev_out_ff);
    evout_sel = MCSL_EO_SWEEP_END;
    trig_armed_mode = 1;
    sweep_done = 1;
    n = 0;
    hi(1, 2);
    sweep_done = 0;
    hi(SWP + 20, 2);
    chk("sweep", SWP, n[15:0]);
    $display("done events");
    complete_run;
  end
endmodule // mcsl_top_test
bind mcsl_top mcsl_top_properties chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .role_ff(role_ff),
  .tx_en_ff(tx_en_ff), .led_sig_ff(led_sig_ff), .led_data_ff(led_data_ff), .rx_sig_det(rx_sig_det),
  .rx_aligned(rx_aligned), .rx_valid(rx_valid), .time_rec_en_ff(time_rec_en_ff), .rec_active(rec_active),
  .evout_sel(evout_sel), .ev_out_ff(ev_out_ff), .cyc_event_ff(cyc_event_ff), .sys_stop_ff(sys_stop_ff));
